// ===== src/sysi_regbank.sv
// Notes on behaviour
// - Clear keep-alive gates clock during Stop
// - Set keep-alive runs clock if enabled
// - Interval timer keep-alives at bits 14-12
// - Timer channel keep-alives bits 3-0, reset zero
// - Short address: 6 instruction bits, 18 base
// - High base bits 1-0 give address 23:22
// - Low base gives address bits 21 to 6
// - Short base resets to all ones
// - New base effective five cycles after write
// - Clock protect field guards clock registers
// - Pin protect field guards pin select registers
// - Field codes: off, on, off-locked, on-locked
// - Unlocked field toggles freely by software
// - Locked field changes only by reset
// - Pin protect also guards clock output test fields
// - Clear keep-alive disables clock entering Stop
// - Clock enable bits match keep-alive positions
`include "sysint_defines.svh"

module sysi_regbank
    import sysi_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Stop-mode clock gating
    input  wire logic        i_stop_mode,
    output logic      [6:0]  o_periph_clk_en,
    // Short I/O addressing
    input  wire logic [5:0]  i_short_ofs,
    output logic      [23:0] o_short_addr,
    // Protection outputs to other register owners
    output logic             o_clock_ctrl_protect,
    output logic             o_pin_select_protect
);

    // ============================================================
    // State
    // ============================================================
    typedef struct packed {
        logic [15:0] pce1;
        logic [15:0] keep1;
        logic [1:0]  sahi;
        logic [15:0] salo;
        logic [6:0]  clk_en;
        logic [31:0] prdata;
        logic        pslverr;
    } sysi_state_t;

    sysi_state_t  state_q;
    sysi_state_t  state_d;
    sysi_prot_t   clk_prot_val;
    sysi_prot_t   pin_prot_val;
    logic         clk_prot_on;
    logic         pin_prot_on;
    sysi_sabase_t sa_eff;
    logic [7:0]   idx;
    logic         setup;
    logic         acc_phase;
    logic         wr_prot;

    // Gather the seven gated peripherals: timers 2..0 then channels 3..0
    function automatic logic [6:0] sysi_pick(input logic [15:0] r);
        sysi_pick = {r[`SYSI_BIT_IT2:`SYSI_BIT_IT0], r[`SYSI_BIT_TCH3:`SYSI_BIT_TCH0]};
    endfunction : sysi_pick

    function automatic logic sysi_hit(input logic [7:0] a, input logic [7:0] ref_idx);
        sysi_hit = (a == ref_idx);
    endfunction : sysi_hit

    // ============================================================
    // Bus decode
    // ============================================================
    // Zero-wait slave: reads captured in setup, writes land at the access edge
    assign idx       = i_paddr[9:2];
    assign setup     = i_psel && !i_penable;
    assign acc_phase = i_psel && i_penable;
    assign wr_prot   = acc_phase && i_pwrite && sysi_hit(idx, `SYSI_IDX_PROT);

    sysi_prot_field u_clk_prot (
        .i_clk     (i_clk),
        .i_nrst    (i_nrst),
        .i_wr      (wr_prot),
        .i_wdata   (i_pwdata[`SYSI_PROT_CLK_LSB +: 2]),
        .o_value   (clk_prot_val),
        .o_protect (clk_prot_on)
    );

    sysi_prot_field u_pin_prot (
        .i_clk     (i_clk),
        .i_nrst    (i_nrst),
        .i_wr      (wr_prot),
        .i_wdata   (i_pwdata[`SYSI_PROT_PIN_LSB +: 2]),
        .o_value   (pin_prot_val),
        .o_protect (pin_prot_on)
    );

    sysi_sa_delay u_sa_delay (
        .i_clk  (i_clk),
        .i_nrst (i_nrst),
        .i_base ({state_q.sahi, state_q.salo}),
        .o_base (sa_eff)
    );

    // ============================================================
    // Next state
    // ============================================================
    always_comb
    begin
        state_d = state_q;
        state_d.pslverr = 1'b0;
        if (setup)
        begin
            state_d.prdata = 32'h0000_0000;
            if (i_pwrite)
            begin
                // Flagged in setup so the error stands through the access cycle
                if (!sysi_hit(idx, `SYSI_IDX_PROT) && !sysi_hit(idx, `SYSI_IDX_PCE1)
                    && !sysi_hit(idx, `SYSI_IDX_STOPKEEP1) && !sysi_hit(idx, `SYSI_IDX_SAHI)
                    && !sysi_hit(idx, `SYSI_IDX_SALO))
                begin
                    state_d.pslverr = 1'b1;
                end
            end
            else
            begin
                case (idx)
                    `SYSI_IDX_PCE1:      state_d.prdata = {16'h0000, state_q.pce1};
                    `SYSI_IDX_STOPKEEP1: state_d.prdata = {16'h0000, state_q.keep1};
                    `SYSI_IDX_SAHI:      state_d.prdata = {30'h0000_0000, state_q.sahi};
                    `SYSI_IDX_SALO:      state_d.prdata = {16'h0000, state_q.salo};
                    `SYSI_IDX_PROT:      state_d.prdata = {28'h000_0000, clk_prot_val, pin_prot_val};
                    default:             state_d.pslverr = 1'b1;
                endcase
            end
        end
        // Writes take effect only at the edge where pready is seen
        if (acc_phase && i_pwrite)
        begin
            // Protected registers silently keep their value
            if (sysi_hit(idx, `SYSI_IDX_PCE1) && !clk_prot_on)
            begin
                state_d.pce1 = i_pwdata[15:0] & `SYSI_KEEP_MASK;
            end
            else if (sysi_hit(idx, `SYSI_IDX_STOPKEEP1) && !clk_prot_on)
            begin
                state_d.keep1 = i_pwdata[15:0] & `SYSI_KEEP_MASK;
            end
            else if (sysi_hit(idx, `SYSI_IDX_SAHI))
            begin
                state_d.sahi = i_pwdata[1:0];
            end
            else if (sysi_hit(idx, `SYSI_IDX_SALO))
            begin
                state_d.salo = i_pwdata[15:0];
            end
        end
        // Outside Stop every enabled clock runs; in Stop only kept ones
        if (i_stop_mode)
        begin
            state_d.clk_en = sysi_pick(state_q.pce1) & sysi_pick(state_q.keep1);
        end
        else
        begin
            state_d.clk_en = sysi_pick(state_q.pce1);
        end
    end

    // ============================================================
    // Registers
    // ============================================================
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state_q.pce1    <= 16'h0000;
            state_q.keep1   <= 16'h0000;
            state_q.sahi    <= `SYSI_SAHI_RESET;
            state_q.salo    <= `SYSI_SALO_RESET;
            state_q.clk_en  <= 7'h00;
            state_q.prdata  <= 32'h0000_0000;
            state_q.pslverr <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ============================================================
    // Outputs
    // ============================================================
    assign o_prdata             = state_q.prdata;
    assign o_pslverr            = state_q.pslverr;
    assign o_pready             = 1'b1;
    assign o_periph_clk_en      = state_q.clk_en;
    assign o_short_addr         = {sa_eff.high, sa_eff.low, i_short_ofs};
    assign o_clock_ctrl_protect = clk_prot_on;
    // Also covers test-only clock output waveform fields elsewhere
    assign o_pin_select_protect = pin_prot_on;

endmodule : sysi_regbank

// ===== src/sysint_defines.svh
`ifndef SYSINT_DEFINES_SVH
`define SYSINT_DEFINES_SVH

// Register indices as printed; byte address is four times the index
`define SYSI_IDX_PCE1        8'h0D
`define SYSI_IDX_STOPKEEP1   8'h0F
`define SYSI_IDX_SAHI        8'h10
`define SYSI_IDX_SALO        8'h11
`define SYSI_IDX_PROT        8'h12

// Keep-alive and clock-enable field positions
`define SYSI_BIT_IT2         14
`define SYSI_BIT_IT1         13
`define SYSI_BIT_IT0         12
`define SYSI_BIT_TCH3        3
`define SYSI_BIT_TCH0        0
`define SYSI_KEEP_MASK       16'h700F

// Short address layout
`define SYSI_SAHI_MASK       16'h0003
`define SYSI_SALO_MASK       16'hFFFF
`define SYSI_SAHI_RESET      2'h3
`define SYSI_SALO_RESET      16'hFFFF
`define SYSI_SA_OFS_W        6
`define SYSI_SA_DELAY        5

// Protection register layout
`define SYSI_PROT_CLK_LSB    2
`define SYSI_PROT_PIN_LSB    0
`define SYSI_PROT_RESET      2'h0
`define SYSI_PROT_ON_BIT     0
`define SYSI_PROT_LOCK_BIT   1

`endif

// ===== src/sysi_pkg.sv
package sysi_pkg;

    // Stop-mode gating inputs
    typedef struct packed {
        logic       stop_mode;
        logic [6:0] clk_request;
    } sysi_gate_in_t;

    // One protection field: bit1 lock, bit0 protect
    typedef logic [1:0] sysi_prot_t;

    // Short address base pipeline stage
    typedef struct packed {
        logic [1:0]  high;
        logic [15:0] low;
    } sysi_sabase_t;

    typedef enum logic [1:0] {
        SYSI_APB_IDLE,
        SYSI_APB_ACCESS
    } sysi_apb_state_t;

endpackage : sysi_pkg

// ===== src/sysi_prot_field.sv
`include "sysint_defines.svh"

module sysi_prot_field
    import sysi_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_nrst,
    // Software write
    input  wire logic       i_wr,
    input  wire sysi_prot_t i_wdata,
    // Field state
    output sysi_prot_t      o_value,
    output logic            o_protect
);

    typedef struct packed {
        sysi_prot_t value;
    } sysi_pf_state_t;

    sysi_pf_state_t state_q;
    sysi_pf_state_t state_d;

    always_comb
    begin
        state_d = state_q;
        // Locked fields ignore every write until reset
        if (i_wr && !state_q.value[`SYSI_PROT_LOCK_BIT])
        begin
            state_d.value = i_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state_q.value <= `SYSI_PROT_RESET;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign o_value   = state_q.value;
    assign o_protect = state_q.value[`SYSI_PROT_ON_BIT];

endmodule : sysi_prot_field

// ===== src/sysi_sa_delay.sv
`include "sysint_defines.svh"

module sysi_sa_delay
    import sysi_pkg::*;
#(
    parameter int DEPTH = `SYSI_SA_DELAY
)
(
    // Clock and reset
    input  wire logic   i_clk,
    input  wire logic   i_nrst,
    // Base as written and base in effect
    input  sysi_sabase_t i_base,
    output sysi_sabase_t o_base
);

    typedef struct packed {
        sysi_sabase_t [DEPTH-1:0] stage;
    } sysi_sd_state_t;

    sysi_sd_state_t state_q;
    sysi_sd_state_t state_d;

    // Matches the core pipeline so a new base lands after five cycles
    always_comb
    begin
        state_d = state_q;
        state_d.stage[0] = i_base;
        for (int i = 1; i < DEPTH; i++)
        begin
            state_d.stage[i] = state_q.stage[i-1];
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                state_q.stage[i].high <= `SYSI_SAHI_RESET;
                state_q.stage[i].low  <= `SYSI_SALO_RESET;
            end
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign o_base = state_q.stage[DEPTH-1];

endmodule : sysi_sa_delay

// ===== dv/sysi_regbank_properties.sv
`include "sysint_defines.svh"

// =====
// Port checker
module sysi_regbank_chk
(
    // Clock and reset
    input wire logic        i_clk,
    input wire logic        i_nrst,
    // APB
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    // Side outputs
    input wire logic        i_stop_mode,
    input wire logic [6:0]  o_periph_clk_en,
    input wire logic [5:0]  i_short_ofs,
    input wire logic [23:0] o_short_addr,
    input wire logic        o_clock_ctrl_protect,
    input wire logic        o_pin_select_protect
);
    logic [7:0] idx;
    logic       rd;
    logic       wr;
    logic       wsa;
    logic       wck;
    logic       lk_c_q;
    logic       lk_p_q;
    assign idx = i_paddr[9:2];
    assign rd  = i_psel && i_penable && !i_pwrite;
    assign wr  = i_psel && i_penable && i_pwrite;
    assign wsa = wr && (idx == `SYSI_IDX_SAHI || idx == `SYSI_IDX_SALO);
    assign wck = wr && (idx == `SYSI_IDX_PCE1 || idx == `SYSI_IDX_STOPKEEP1);
    // A lock bit never clears before reset, so ignored writes cannot mislead this
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            lk_c_q <= 1'h0;
            lk_p_q <= 1'h0;
        end
        else if (wr && idx == `SYSI_IDX_PROT)
        begin
            lk_c_q <= lk_c_q | i_pwdata[3];
            lk_p_q <= lk_p_q | i_pwdata[1];
        end
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);
    AST_KEEP_RSV: assert property (rd && idx == `SYSI_IDX_STOPKEEP1 |-> (o_prdata & ~32'h700F) == 32'h0)
        else $error("keep-alive reserved bits set");
    AST_SAHI_RSV: assert property (rd && idx == `SYSI_IDX_SAHI |-> o_prdata[31:2] == 30'h0)
        else $error("high base reserved bits set");
    AST_PROT_RD: assert property (rd && idx == `SYSI_IDX_PROT |-> o_prdata[31:4] == 28'h0
        && o_prdata[2] == o_clock_ctrl_protect && o_prdata[0] == o_pin_select_protect)
        else $error("protect outputs differ from register");
    AST_SA_OFS: assert property (o_short_addr[5:0] == i_short_ofs)
        else $error("short offset not passed through");
    AST_SA_DLY: assert property ($changed(o_short_addr[23:6]) |-> $past(wsa, 6))
        else $error("short base changed at wrong time");
    AST_CLK_CHG: assert property ($changed(o_periph_clk_en) |->
        $past(i_stop_mode) != $past(i_stop_mode, 2) || $past(wck, 2))
        else $error("clock enables changed without cause");
    AST_CLK_WR: assert property (wr && idx == `SYSI_IDX_PROT && !lk_c_q |=>
        o_clock_ctrl_protect == $past(i_pwdata[2]))
        else $error("clock protect not written");
    AST_PIN_WR: assert property (wr && idx == `SYSI_IDX_PROT && !lk_p_q |=>
        o_pin_select_protect == $past(i_pwdata[0]))
        else $error("pin protect not written");
    AST_CLK_LOCK: assert property ($past(lk_c_q) |-> $stable(o_clock_ctrl_protect))
        else $error("locked clock protect changed");
    AST_PIN_LOCK: assert property ($past(lk_p_q) |-> $stable(o_pin_select_protect))
        else $error("locked pin protect changed");
endmodule : sysi_regbank_chk

bind sysi_regbank sysi_regbank_chk chk_u
(
    .i_clk, .i_nrst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
    .o_pready, .o_pslverr, .i_stop_mode, .o_periph_clk_en, .i_short_ofs, .o_short_addr,
    .o_clock_ctrl_protect, .o_pin_select_protect
);

// ===== dv/sysint_stop_shortaddr_protect_test.sv
`include "sysint_defines.svh"

// =====
// Register bank bench
module sysint_stop_shortaddr_protect_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_clk       = 1'h0;
    logic        i_nrst      = 1'h0;
    logic        i_psel      = 1'h0;
    logic        i_penable   = 1'h0;
    logic        i_pwrite    = 1'h0;
    logic [11:0] i_paddr     = 12'h0;
    logic [31:0] i_pwdata    = 32'h0;
    logic        i_stop_mode = 1'h0;
    logic [5:0]  i_short_ofs = 6'h2A;
    logic [31:0] o_prdata;
    logic        o_pready;
    logic        o_pslverr;
    logic [6:0]  o_periph_clk_en;
    logic [23:0] o_short_addr;
    logic        o_clock_ctrl_protect;
    logic        o_pin_select_protect;
    logic [31:0] rdat;
    logic        rerr;
    logic [3:0]  pv;
    logic [3:0]  lockv [2] = '{4'hE, 4'hB};
    int          err_count   = 0;
    int          check_count = 0;

    sysi_regbank dut_u
    (
        .i_clk, .i_nrst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
        .o_pready, .o_pslverr, .i_stop_mode, .o_periph_clk_en, .i_short_ofs, .o_short_addr,
        .o_clock_ctrl_protect, .o_pin_select_protect
    );

    always #20 i_clk = ~i_clk;

    task automatic report_and_stop();
        if (err_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask : check

    // Read data is taken at the edge where pready is seen, before flops move
    task automatic apb(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
        @(posedge i_clk);
        i_psel    <= 1'h1;
        i_penable <= 1'h0;
        i_pwrite  <= wr;
        i_paddr   <= {2'h0, idx, 2'h0};
        i_pwdata  <= wd;
        @(posedge i_clk);
        i_penable <= 1'h1;
        do
            @(posedge i_clk);
        while (o_pready !== 1'h1);
        rdat = o_prdata;
        rerr = o_pslverr;
        i_psel    <= 1'h0;
        i_penable <= 1'h0;
    endtask : apb

    task automatic rdchk(input string n, input logic [7:0] idx, input logic [31:0] exp);
        apb(idx, 1'h0, 32'h0);
        check(n, rdat, exp);
    endtask : rdchk

    task automatic do_reset();
        i_nrst <= 1'h0;
        repeat (20) @(posedge i_clk);
        i_nrst <= 1'h1;
    endtask : do_reset

    function automatic logic [31:0] en7(input logic [15:0] x);
        return {25'h0, x[14:12], x[3:0]};
    endfunction : en7

    initial
    begin
        repeat (3000) @(posedge i_clk);
        err_count++;
        report_and_stop();
    end

    initial
    begin
        do_reset();
        rdchk("keep", `SYSI_IDX_STOPKEEP1, 32'h0);
        check("keep err", {31'h0, rerr}, 32'h0);
        rdchk("sahi", `SYSI_IDX_SAHI, 32'h3);
        rdchk("salo", `SYSI_IDX_SALO, 32'hFFFF);
        rdchk("prot", `SYSI_IDX_PROT, 32'h0);
        rdchk("unmapped", 8'h20, 32'h0);
        check("unmapped err", {31'h0, rerr}, 32'h1);
        @(negedge i_clk);
        check("sa reset", {8'h0, o_short_addr}, {8'h0, 18'h3FFFF, 6'h2A});
        apb(`SYSI_IDX_PCE1, 1'h1, 32'h5005);
        apb(`SYSI_IDX_STOPKEEP1, 1'h1, 32'h300C);
        rdchk("keep", `SYSI_IDX_STOPKEEP1, 32'h300C);
        i_stop_mode <= 1'h1;
        @(negedge i_clk);
        check("run en", {25'h0, o_periph_clk_en}, en7(16'h5005));
        @(negedge i_clk);
        check("stop en", {25'h0, o_periph_clk_en}, en7(16'h1004));
        apb(`SYSI_IDX_STOPKEEP1, 1'h1, 32'h0);
        repeat (2) @(negedge i_clk);
        check("stop off", {25'h0, o_periph_clk_en}, 32'h0);
        @(posedge i_clk);
        i_stop_mode <= 1'h0;
        apb(`SYSI_IDX_SALO, 1'h1, 32'h1234);
        i_short_ofs <= 6'h15;
        repeat (5) @(negedge i_clk);
        check("sa old", {8'h0, o_short_addr}, {8'h0, 18'h3FFFF, 6'h15});
        @(negedge i_clk);
        check("sa new", {8'h0, o_short_addr}, {8'h0, 2'h3, 16'h1234, 6'h15});
        apb(`SYSI_IDX_SAHI, 1'h1, 32'h1);
        rdchk("salo", `SYSI_IDX_SALO, 32'h1234);
        repeat (6) @(negedge i_clk);
        check("sa hi", {8'h0, o_short_addr}, {8'h0, 2'h1, 16'h1234, 6'h15});
        apb(`SYSI_IDX_PROT, 1'h1, 32'h5);
        @(negedge i_clk);
        check("prot on", {30'h0, o_clock_ctrl_protect, o_pin_select_protect}, 32'h3);
        apb(`SYSI_IDX_PCE1, 1'h1, 32'h0);
        rdchk("pce held", `SYSI_IDX_PCE1, 32'h5005);
        apb(`SYSI_IDX_PROT, 1'h1, 32'h0);
        rdchk("prot off", `SYSI_IDX_PROT, 32'h0);
        foreach (lockv[i])
        begin
            pv = lockv[i];
            apb(`SYSI_IDX_PROT, 1'h1, {28'h0, pv});
            apb(`SYSI_IDX_PROT, 1'h1, 32'h0);
            rdchk("locked", `SYSI_IDX_PROT, {28'h0, pv});
            check("lock out", {30'h0, o_clock_ctrl_protect, o_pin_select_protect},
                {30'h0, pv[2], pv[0]});
            apb(`SYSI_IDX_STOPKEEP1, 1'h1, 32'h7);
            rdchk("keep lock", `SYSI_IDX_STOPKEEP1, pv[2] ? 32'h0 : 32'h7);
            do_reset();
            rdchk("prot rst", `SYSI_IDX_PROT, 32'h0);
        end
        report_and_stop();
    end
endmodule : sysint_stop_shortaddr_protect_test
